// >>> core/cmd_decoder.sv
// memory-side decoder of command codes on the command port
`timescale 1ns/1ps
module cmd_decoder
    import cmd_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clock_in,
    input  wire logic              nrst_in,
    input  wire logic              en_in,
    // command pins
    cmd_if.mem                     pins,
    // decoded result
    output logic [3:0]             cmd_out,
    output logic                   cmd_valid_out,
    output logic [BANK_W-1:0]      bank_out,
    output logic [ADDR_W-1:0]      addr_out,
    output logic                   auto_pre_out,
    output logic [MR_W-1:0]        mode_sel_out,
    output logic [2:0]             pwr_state_out,
    output logic                   illegal_out
);
    // ------------------------------------------------------------
    // previous-cycle clock enable and classification
    // ------------------------------------------------------------
    logic   cke_prev_q;
    cmd_e   cmd_d;
    pwr_e   pwr_q;
    pwr_e   pwr_d;
    logic   nop_or_desel;
    logic   sr_wake;      // self-refresh exit seen this edge
    logic   keep_addr;    // code carries bank or address
    logic   col_cmd;      // read or write code
    logic   exec_cmd;     // code the memory acts on

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cke_prev_q <= 1'b0;
        end else if (en_in) begin
            cke_prev_q <= pins.clk_en;
        end
    end

    // idle code: chip deselected or an explicit no-op,
    // the only codes allowed on a rise of the enable; a fall also takes the refresh code
    assign nop_or_desel = pins.sel_n | (pins.row_n & pins.col_n & pins.wr_n);

    // code classification
    always_comb begin
        cmd_d = CMD_ILLEGAL;
        if (pwr_q == ST_SREF) begin
            if (pins.clk_en && nop_or_desel) begin
                cmd_d = CMD_SR_OUT;
            end else if (!pins.clk_en) begin
                cmd_d = CMD_DESEL;
            end
        end else if (!cke_prev_q) begin
            if (pins.clk_en && nop_or_desel) begin
                cmd_d = CMD_PD_OUT;
            end else if (!pins.clk_en) begin
                cmd_d = CMD_DESEL;
            end
        end else if (!pins.clk_en) begin
            if (nop_or_desel) begin
                cmd_d = CMD_PD_IN;
            end else if ({pins.row_n, pins.col_n, pins.wr_n} == 3'b001) begin
                cmd_d = CMD_SR_IN;
            end
        end else if (pins.sel_n) begin
            cmd_d = CMD_DESEL;
        end else begin
            case ({pins.row_n, pins.col_n, pins.wr_n})
                3'b000: cmd_d = CMD_MODE;
                3'b001: cmd_d = CMD_REFRESH;
                3'b010: cmd_d = pins.addr[AP_BIT] ? CMD_PRE_ALL : CMD_PRE;
                3'b011: cmd_d = CMD_ACT;
                3'b100: cmd_d = CMD_WRITE;
                3'b101: cmd_d = CMD_READ;
                3'b111: cmd_d = CMD_NOP;
                default: cmd_d = CMD_ILLEGAL;
            endcase
        end
    end

    // ------------------------------------------------------------
    // power state
    // ------------------------------------------------------------
    always_comb begin
        pwr_d = pwr_q;
        case (cmd_d)
            CMD_SR_IN:  pwr_d = ST_SREF;
            CMD_PD_IN:  pwr_d = ST_PDOWN;
            CMD_SR_OUT: pwr_d = ST_ACTIVE;
            CMD_PD_OUT: pwr_d = ST_ACTIVE;
            default:    pwr_d = pwr_q;
        endcase
    end

    // exit honoured even with the enable low
    // the wake is still taken on a clock edge
    assign sr_wake = (pwr_q == ST_SREF) && (cmd_d == CMD_SR_OUT);

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            pwr_q <= ST_ACTIVE;
        end else if (en_in || sr_wake) begin
            pwr_q <= pwr_d;
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    // codes that carry a bank or address worth keeping
    assign keep_addr = cmd_d inside {CMD_MODE, CMD_PRE, CMD_ACT, CMD_WRITE, CMD_READ};
    // column codes carry the auto precharge request
    assign col_cmd   = cmd_d inside {CMD_WRITE, CMD_READ};
    // idle and reserved codes never count as work
    assign exec_cmd  = (cmd_d != CMD_DESEL) && (cmd_d != CMD_NOP)
                       && (cmd_d != CMD_ILLEGAL);

    // decoded code, one per sampled edge
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cmd_out       <= CMD_DESEL;
            cmd_valid_out <= 1'b0;
        end else if (en_in) begin
            cmd_out       <= cmd_d;
            cmd_valid_out <= exec_cmd;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            illegal_out <= 1'b0;
        end else if (en_in) begin
            illegal_out <= (cmd_d == CMD_ILLEGAL);
        end
    end

    // bank and address held until next addressed code
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bank_out <= '0;
            addr_out <= '0;
        end else if (en_in && keep_addr) begin
            bank_out <= pins.bank;
            addr_out <= pins.addr;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            auto_pre_out <= 1'b0;
        end else if (en_in) begin
            auto_pre_out <= col_cmd && pins.addr[AP_BIT];
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            mode_sel_out <= '0;
        end else if (en_in) begin
            mode_sel_out <= (cmd_d == CMD_MODE)
                            ? MR_W'(4'h1 << pins.bank[1:0]) : '0;
        end
    end

    // ------------------------------------------------------------
    // power state seen by the user
    // ------------------------------------------------------------
    assign pwr_state_out = pwr_q;
endmodule : cmd_decoder

// >>> inc/cmd_pkg.sv
// shared constants and types for the command port decoder and its driver
package cmd_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int BANK_W    = 3;
    localparam int ADDR_W    = 14;
    localparam int AP_BIT    = 10;    // address bit for auto/all precharge
    localparam int COL_W     = 10;    // column bits below the precharge bit
    localparam int MR_W      = 4;     // one flag per mode register
    localparam logic [2:0] RCW_RESET = 3'h7;

    // ------------------------------------------------------------
    // decoded command codes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_DESEL   = 4'h0,
        CMD_NOP     = 4'h1,
        CMD_MODE    = 4'h2,
        CMD_REFRESH = 4'h3,
        CMD_SR_IN   = 4'h4,
        CMD_SR_OUT  = 4'h5,
        CMD_PRE     = 4'h6,
        CMD_PRE_ALL = 4'h7,
        CMD_ACT     = 4'h8,
        CMD_WRITE   = 4'h9,
        CMD_READ    = 4'ha,
        CMD_PD_IN   = 4'hb,
        CMD_PD_OUT  = 4'hc,
        CMD_ILLEGAL = 4'hf
    } cmd_e;

    // power state held by the decoder
    typedef enum logic [2:0] {
        ST_ACTIVE = 3'b001,
        ST_PDOWN  = 3'b010,
        ST_SREF   = 3'b100
    } pwr_e;
endpackage : cmd_pkg

// >>> inc/cmd_if.sv
// command/address pin bundle between controller and memory decoder
`timescale 1ns/1ps
interface cmd_if;
    import cmd_pkg::*;
    logic              clk_en;
    logic              sel_n;
    logic              row_n;
    logic              col_n;
    logic              wr_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;

    modport ctrl (output clk_en, sel_n, row_n, col_n, wr_n, bank, addr);
    modport mem  (input  clk_en, sel_n, row_n, col_n, wr_n, bank, addr);
endinterface : cmd_if

// >>> core/cmd_driver.sv
// controller-side driver that encodes requested commands onto the pins
`timescale 1ns/1ps
module cmd_driver
    import cmd_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clock_in,
    input  wire logic              nrst_in,
    input  wire logic              en_in,
    // user request
    input  wire logic              req_in,
    input  wire logic [3:0]        cmd_in,
    input  wire logic [BANK_W-1:0] bank_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              auto_pre_in,
    output logic                   ready_out,
    // pins
    cmd_if.ctrl                    pins
);
    // ------------------------------------------------------------
    // registered pin values
    // ------------------------------------------------------------
    logic              cke_q;
    logic              sel_n_q;
    logic [2:0]        rcw_q;
    logic [BANK_W-1:0] bank_q;
    logic [ADDR_W-1:0] addr_q;
    logic              cke_d;
    logic              sel_n_d;
    logic [2:0]        rcw_d;

    assign ready_out = en_in;

    // encode request; default keeps enable, deselects
    always_comb begin
        cke_d   = cke_q;
        sel_n_d = 1'b1;
        rcw_d   = RCW_RESET;
        if (req_in) begin
            case (cmd_e'(cmd_in))
                CMD_MODE:    begin sel_n_d = 1'b0; rcw_d = 3'b000; cke_d = 1'b1; end
                CMD_REFRESH: begin sel_n_d = 1'b0; rcw_d = 3'b001; cke_d = 1'b1; end
                CMD_SR_IN:   begin sel_n_d = 1'b0; rcw_d = 3'b001; cke_d = 1'b0; end
                CMD_PRE,
                CMD_PRE_ALL: begin sel_n_d = 1'b0; rcw_d = 3'b010; cke_d = 1'b1; end
                CMD_ACT:     begin sel_n_d = 1'b0; rcw_d = 3'b011; cke_d = 1'b1; end
                CMD_WRITE:   begin sel_n_d = 1'b0; rcw_d = 3'b100; cke_d = 1'b1; end
                CMD_READ:    begin sel_n_d = 1'b0; rcw_d = 3'b101; cke_d = 1'b1; end
                CMD_NOP:     begin sel_n_d = 1'b0; rcw_d = 3'b111; end
                CMD_PD_IN:   cke_d = 1'b0;
                CMD_PD_OUT,
                CMD_SR_OUT:  cke_d = 1'b1;
                default:     cke_d = cke_q;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cke_q   <= 1'b0;
            sel_n_q <= 1'b1;
            rcw_q   <= RCW_RESET;
            bank_q  <= '0;
            addr_q  <= '0;
        end else if (en_in) begin
            cke_q   <= cke_d;
            sel_n_q <= sel_n_d;
            rcw_q   <= rcw_d;
            bank_q  <= bank_in;
            addr_q  <= addr_in;
            if (req_in && cmd_e'(cmd_in) inside {CMD_WRITE, CMD_READ}) begin
                addr_q[AP_BIT] <= auto_pre_in;
            end else if (req_in && cmd_e'(cmd_in) == CMD_PRE_ALL) begin
                addr_q[AP_BIT] <= 1'b1;
            end else if (req_in && cmd_e'(cmd_in) == CMD_PRE) begin
                addr_q[AP_BIT] <= 1'b0;
            end
        end
    end

    assign pins.clk_en = cke_q;
    assign pins.sel_n  = sel_n_q;
    assign pins.row_n  = rcw_q[2];
    assign pins.col_n  = rcw_q[1];
    assign pins.wr_n   = rcw_q[0];
    assign pins.bank   = bank_q;
    assign pins.addr   = addr_q;
endmodule : cmd_driver

// >>> test/cmd_port_properties.sv
// concurrent checks on the command pins and the decoded result
`timescale 1ns/1ps
module cmd_port_properties
    import cmd_pkg::*;
(
    // clock and reset
    input wire logic              clock_in,
    input wire logic              nrst_in,
    // command pins
    input wire logic              clk_en,
    input wire logic              sel_n,
    input wire logic              row_n,
    input wire logic              col_n,
    input wire logic              wr_n,
    input wire logic [BANK_W-1:0] bank,
    input wire logic [ADDR_W-1:0] addr,
    // decoded result
    input wire logic [3:0]        cmd_out,
    input wire logic [BANK_W-1:0] bank_out,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic              auto_pre_out,
    input wire logic [MR_W-1:0]   mode_sel_out,
    input wire logic [2:0]        pwr_state_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic       cke_prev_q;
    wire  [3:0] code = {sel_n, row_n, col_n, wr_n};
    wire        run  = cke_prev_q & clk_en;
    wire        idle = sel_n | (code == 4'h7);

    // previous-cycle clock enable, cleared like the decoder's copy
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cke_prev_q <= 1'b0;
        end else begin
            cke_prev_q <= clk_en;
        end
    end

    // ------------------------------------------------------------
    // decode checks
    // ------------------------------------------------------------
    a_mode_load: assert property (run && code == 4'h0 |=> cmd_out == CMD_MODE
        && mode_sel_out == (4'h1 << $past(bank[1:0]))) else $error("mode load mis-decoded");
    a_refresh_decode: assert property (run && code == 4'h1 |=> cmd_out == CMD_REFRESH)
        else $error("refresh mis-decoded");
    a_self_ref_entry: assert property (cke_prev_q && !clk_en && code == 4'h1 |=>
        cmd_out == CMD_SR_IN && pwr_state_out == ST_SREF) else $error("self-refresh entry bad");
    a_precharge_kind: assert property (run && code == 4'h2 |=>
        cmd_out == ($past(addr[AP_BIT]) ? CMD_PRE_ALL : CMD_PRE)) else $error("precharge bad");
    a_pre_bank_kept: assert property (run && code == 4'h2 && !addr[AP_BIT] |=>
        bank_out == $past(bank)) else $error("precharge bank lost");
    a_activate_row: assert property (run && code == 4'h3 |=> cmd_out == CMD_ACT
        && addr_out == $past(addr) && bank_out == $past(bank)) else $error("activate bad");
    a_column_access: assert property (run && code[3:1] == 3'h2 |=>
        cmd_out == ($past(wr_n) ? CMD_READ : CMD_WRITE)
        && auto_pre_out == $past(addr[AP_BIT])) else $error("column access bad");
    a_idle_decode: assert property (run && idle |=>
        cmd_out == ($past(sel_n) ? CMD_DESEL : CMD_NOP)) else $error("idle code bad");
    a_pdown_entry: assert property (cke_prev_q && !clk_en && idle |=>
        cmd_out == CMD_PD_IN && pwr_state_out == ST_PDOWN) else $error("power-down entry bad");
    a_wake_code: assert property (!cke_prev_q && clk_en |-> idle)
        else $error("wake without idle code");
    a_wake_exit: assert property (!cke_prev_q && clk_en && idle |=>
        pwr_state_out == ST_ACTIVE && cmd_out ==
        ($past(pwr_state_out) == ST_SREF ? CMD_SR_OUT : CMD_PD_OUT)) else $error("wake bad");
    // column code followed by an idle edge
    a_burst_whole: assert property (run && !sel_n && row_n && !col_n |=> idle)
        else $error("burst interrupted");
endmodule : cmd_port_properties

// >>> test/tb_top.sv
// end-to-end bench: driver and decoder joined by the pin bundle
`timescale 1ns/1ps
module tb_top
    import cmd_pkg::*;
;
    `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
        $display("[ERR] %0t got %h exp %h", $time, g, e); end end
    logic clock_in, nrst_in, en_in, req_in, auto_pre_in, ready_out;
    logic cmd_valid_out, auto_pre_out, illegal_out;
    logic [3:0] cmd_in, cmd_out, mode_sel_out;
    logic [2:0] bank_in, bank_out, pwr_state_out;
    logic [13:0] addr_in, addr_out;
    int miscompares = 0;
    int tests_run = 0;
    cmd_if pins_if();
    cmd_driver cmd_driver_inst (.clock_in(clock_in), .nrst_in(nrst_in), .en_in(en_in),
        .req_in(req_in), .cmd_in(cmd_in), .bank_in(bank_in), .addr_in(addr_in),
        .auto_pre_in(auto_pre_in), .ready_out(ready_out), .pins(pins_if.ctrl));
    cmd_decoder cmd_decoder_inst (.clock_in(clock_in), .nrst_in(nrst_in), .en_in(en_in),
        .pins(pins_if.mem), .cmd_out(cmd_out), .cmd_valid_out(cmd_valid_out),
        .bank_out(bank_out), .addr_out(addr_out), .auto_pre_out(auto_pre_out),
        .mode_sel_out(mode_sel_out), .pwr_state_out(pwr_state_out), .illegal_out(illegal_out));
    cmd_port_properties cmd_port_properties_inst (.clock_in(clock_in), .nrst_in(nrst_in),
        .clk_en(pins_if.clk_en), .sel_n(pins_if.sel_n), .row_n(pins_if.row_n),
        .col_n(pins_if.col_n), .wr_n(pins_if.wr_n), .bank(pins_if.bank), .addr(pins_if.addr),
        .cmd_out(cmd_out), .bank_out(bank_out), .addr_out(addr_out),
        .auto_pre_out(auto_pre_out), .mode_sel_out(mode_sel_out), .pwr_state_out(pwr_state_out));

    // 125 MHz clock
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // verdict and end of run
    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    // one request, checked two edges later at the decoder
    task automatic op(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a,
                      input logic [3:0] exp_c, input logic [2:0] exp_p);
        req_in = 1'b1;
        cmd_in = c;
        bank_in = b;
        addr_in = a;
        auto_pre_in = a[AP_BIT];
        @(negedge clock_in);
        req_in = 1'b0;
        @(negedge clock_in);
        `CHK(cmd_out, exp_c)
        `CHK(pwr_state_out, exp_p)
        `CHK(cmd_valid_out, exp_c > 4'h1 && exp_c != 4'hf)
        `CHK(illegal_out, exp_c == 4'hf)
    endtask : op

    // hang guard
    initial begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        give_verdict();
    end

    // main sequence
    initial begin
        nrst_in = 1'b0;
        en_in = 1'b1;
        req_in = 1'b0;
        cmd_in = 4'h0;
        bank_in = 3'h0;
        addr_in = 14'h0;
        auto_pre_in = 1'b0;
        repeat (6) @(posedge clock_in);
        @(negedge clock_in);
        nrst_in = 1'b1;
        `CHK(ready_out, 1'b1)
        op(CMD_PD_OUT, 3'h0, 14'h0, CMD_PD_OUT, ST_ACTIVE);
        for (int i = 0; i < 4; i++) begin
            op(CMD_MODE, 3'(i + 4), 14'h0400 + 14'(i), CMD_MODE, ST_ACTIVE);
            `CHK(mode_sel_out, 4'h1 << i[1:0])
        end
        op(CMD_REFRESH, 3'h7, 14'h3fff, CMD_REFRESH, ST_ACTIVE);
        op(CMD_ACT, 3'h5, 14'h2abc, CMD_ACT, ST_ACTIVE);
        `CHK(addr_out, 14'h2abc)
        `CHK(bank_out, 3'h5)
        op(CMD_WRITE, 3'h5, 14'h0155, CMD_WRITE, ST_ACTIVE);
        `CHK(auto_pre_out, 1'b0)
        op(CMD_WRITE, 3'h2, 14'h07ff, CMD_WRITE, ST_ACTIVE);
        `CHK(auto_pre_out, 1'b1)
        op(CMD_READ, 3'h2, 14'h0403, CMD_READ, ST_ACTIVE);
        `CHK(auto_pre_out, 1'b1)
        op(CMD_PRE, 3'h3, 14'h0, CMD_PRE, ST_ACTIVE);
        `CHK(bank_out, 3'h3)
        op(CMD_PRE_ALL, 3'h6, 14'h0400, CMD_PRE_ALL, ST_ACTIVE);
        op(CMD_NOP, 3'h1, 14'h1234, CMD_NOP, ST_ACTIVE);
        op(CMD_DESEL, 3'h2, 14'h0fff, CMD_DESEL, ST_ACTIVE);
        en_in = 1'b0;
        req_in = 1'b1;
        cmd_in = CMD_ACT;
        bank_in = 3'h1;
        addr_in = 14'h0111;
        repeat (3) @(negedge clock_in);
        `CHK(ready_out, 1'b0)
        `CHK(cmd_out, CMD_DESEL)
        `CHK(bank_out, 3'h3)
        `CHK(addr_out, 14'h0)
        req_in = 1'b0;
        en_in = 1'b1;
        @(negedge clock_in);
        op(CMD_PD_IN, 3'h0, 14'h0, CMD_PD_IN, ST_PDOWN);
        op(CMD_PD_OUT, 3'h0, 14'h0, CMD_PD_OUT, ST_ACTIVE);
        op(CMD_SR_IN, 3'h0, 14'h0, CMD_SR_IN, ST_SREF);
        op(CMD_SR_OUT, 3'h0, 14'h0, CMD_SR_OUT, ST_ACTIVE);
        give_verdict();
    end
endmodule : tb_top
